//--- logic/tccs_defs.svh
// register indices, field positions, reset values and widths of the capture/compare block
`ifndef TCCS_DEFS_SVH
`define TCCS_DEFS_SVH

// register indices; byte address is four times the index
`define TCCS_IDX_MODE      10'h120
`define TCCS_IDX_CTRL1     10'h121
`define TCCS_IDX_IRQ_EN    10'h122
`define TCCS_IDX_STATUS    10'h123
`define TCCS_IDX_IO_AB     10'h124
`define TCCS_IDX_IO_CD     10'h125
`define TCCS_IDX_COUNTER   10'h126
`define TCCS_IDX_GR_A      10'h128
`define TCCS_IDX_GR_B      10'h12a
`define TCCS_IDX_GR_C      10'h12c
`define TCCS_IDX_GR_D      10'h12e

// flag vector positions, then the status register bit of the wrap flag
`define TCCS_FLAG_A        0
`define TCCS_FLAG_B        1
`define TCCS_FLAG_C        2
`define TCCS_FLAG_D        3
`define TCCS_FLAG_WRAP     4
`define TCCS_STATUS_WRAP   7

// mode register fields and the ctrl1 clear bit
`define TCCS_MODE_PWM_B    0
`define TCCS_MODE_PWM_C    1
`define TCCS_MODE_PWM_D    2
`define TCCS_MODE_PWM2_N   3
`define TCCS_MODE_BUF_C    4
`define TCCS_MODE_BUF_D    5
`define TCCS_MODE_START    7
`define TCCS_CTRL1_CLEAR   7

// io control fields
`define TCCS_IO_A_CAP      2
`define TCCS_IO_A_SRC      3
`define TCCS_IO_B_CAP      6
`define TCCS_IO_C_CAP      2
`define TCCS_IO_C_FUNC     3
`define TCCS_IO_D_CAP      6
`define TCCS_IO_D_FUNC     7

// reset values, bits that always read as one and the counter maximum
`define TCCS_RST_MODE      8'h48
`define TCCS_RST_IO_AB     8'h00
`define TCCS_RST_IO_CD     8'h88
`define TCCS_RST_IRQ_EN    8'h00
`define TCCS_RST_CTRL1     8'h00
`define TCCS_RST_COUNTER   16'h0000
`define TCCS_RST_GR        16'hffff
`define TCCS_ONES_STATUS   8'h70
`define TCCS_ONES_IO_AB    8'h80
`define TCCS_ONES_MODE     8'h40
`define TCCS_ONES_IRQ_EN   8'h70
`define TCCS_CNT_MAX       16'hffff

`endif

//--- logic/tccs_pkg.sv
// types shared by the capture/compare block
package tccs_pkg;

   typedef struct packed {
      logic        psel;
      logic        penable;
      logic        pwrite;
      logic [11:0] paddr;
      logic [31:0] pwdata;
   } tccs_apb_req_t;

   typedef struct packed {
      logic [31:0] prdata;
      logic        pready;
      logic        pslverr;
   } tccs_apb_rsp_t;

   typedef struct packed {
      logic [4:0]       sync1;
      logic [4:0]       sync2;
      logic [4:0]       prev;
      logic [4:0]       flag;
      logic [4:0]       arm;
      logic [7:0]       mode;
      logic [7:0]       ctrl1;
      logic [7:0]       irq_en;
      logic [7:0]       io_ab;
      logic [7:0]       io_cd;
      logic [15:0]      cnt;
      logic [3:0][15:0] gr;
      logic [3:0]       pout;
      logic [31:0]      rdata;
   } tccs_state_t;

endpackage

//--- logic/tccs_top.sv
// timer capture/compare channels, flags, counter and general registers behind apb
//
// Function
// - a flag clears only on a 0 write after it read as 1.
// - writing 0 to a flag that read 0 leaves it, later sets survive.
// - writing 1 to a flag bit leaves the flag, but any status write cancels the earlier read.
// - capture channels set their flag on the pin edge chosen by low bits, c and d only while not buffering.
// - compare, pwm and pwm2 channels set their flag on counter equal register.
// - channels c and d flag matches also while buffering a and b.
// - 16-bit counter ticks once per count tick, readable and writable.
// - counter overflow sets the wrap flag in status bit 7.
// - status bits 4 to 6 read as one.
// - channel mode bit selects compare when 0, capture when 1.
// - channel a capture source: slow oscillator when 0, pin when 1, capture only.
// - channel c function bit 0 makes register c drive pin a output.
// - channel d function bit 0 makes register d drive pin b output.
// - io control registers only act in timer mode, ignored in pwm modes.
// - each flag raises its interrupt request only while enabled.
// - clear select 1 clears counter on channel a capture or match.
//
// The APB slave port was decided locally.
`timescale 1ns/10ps
`include "tccs_defs.svh"

module tccs_top (
   // clock and reset
   input  wire logic                  clk_sys,
   input  wire logic                  rst_b,
   // register bus
   input  wire tccs_pkg::tccs_apb_req_t apb_req,
   output tccs_pkg::tccs_apb_rsp_t    apb_rsp,
   // count source, one-cycle enable
   input  wire logic                  count_tick,
   // channel pins and slow oscillator signal
   input  wire logic                  chan_a_pin,
   input  wire logic                  chan_b_pin,
   input  wire logic                  chan_c_pin,
   input  wire logic                  chan_d_pin,
   input  wire logic                  slow_osc_div_signal,
   output logic [3:0]                 chan_pin_out,
   output logic [3:0]                 chan_pin_oe_b,
   // interrupt requests, order a b c d wrap
   output logic [4:0]                 irq_req
);

   tccs_pkg::tccs_state_t s_q;
   tccs_pkg::tccs_state_t s_d;

   // edge chosen by two low control bits: 00 rising, 01 falling, 1x both
   function automatic logic edge_hit(input logic [1:0] sel, input logic cur, input logic old);
      logic rise;
      logic fall;
      rise = cur & ~old;
      fall = ~cur & old;
      case (sel)
         2'h0:    edge_hit = rise;
         2'h1:    edge_hit = fall;
         default: edge_hit = rise | fall;
      endcase
   endfunction

   // pin action on compare: 00 none, 01 low, 10 high, 11 toggle
   function automatic logic pin_act(input logic [1:0] sel, input logic cur);
      case (sel)
         2'h0:    pin_act = cur;
         2'h1:    pin_act = 1'b0;
         2'h2:    pin_act = 1'b1;
         default: pin_act = ~cur;
      endcase
   endfunction

   logic        pwm2_mode;
   logic [3:0]  timer_mode;
   logic [3:0]  capture_mode;
   logic [3:0]  cap_edge;
   logic [3:0]  match;
   logic [3:0]  cap_ev;
   logic [1:0]  buf_on;
   logic        bus_acc;
   logic        bus_wr;
   logic        bus_rd;
   logic [9:0]  idx;
   logic        mapped;
   logic [7:0]  status_view;
   logic [31:0] rd_mux;
   logic [4:0]  flag_set;
   logic        wrap;
   logic        clr_cnt;
   logic [3:0][1:0] edge_sel;
   logic [3:0]  cap_src;

   assign pwm2_mode = ~s_q.mode[`TCCS_MODE_PWM2_N];
   assign buf_on    = {s_q.mode[`TCCS_MODE_BUF_D], s_q.mode[`TCCS_MODE_BUF_C]};

   // io control only counts in timer mode of each channel
   assign timer_mode[0] = ~pwm2_mode & ~|s_q.mode[2:0];
   assign timer_mode[1] = ~pwm2_mode & ~s_q.mode[`TCCS_MODE_PWM_B];
   assign timer_mode[2] = ~pwm2_mode & ~s_q.mode[`TCCS_MODE_PWM_C];
   assign timer_mode[3] = ~pwm2_mode & ~s_q.mode[`TCCS_MODE_PWM_D];

   // mode bit 1 selects capture
   assign capture_mode[0] = timer_mode[0] & s_q.io_ab[`TCCS_IO_A_CAP];
   assign capture_mode[1] = timer_mode[1] & s_q.io_ab[`TCCS_IO_B_CAP];
   assign capture_mode[2] = timer_mode[2] & s_q.io_cd[`TCCS_IO_C_CAP];
   assign capture_mode[3] = timer_mode[3] & s_q.io_cd[`TCCS_IO_D_CAP];

   assign edge_sel[0] = s_q.io_ab[1:0];
   assign edge_sel[1] = s_q.io_ab[5:4];
   assign edge_sel[2] = s_q.io_cd[1:0];
   assign edge_sel[3] = s_q.io_cd[5:4];

   // sync index 4 is the slow oscillator; source bit only matters in capture
   assign cap_src[0] = s_q.io_ab[`TCCS_IO_A_SRC];
   assign cap_src[3:1] = 3'h7;

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_chan
         logic cur;
         logic old;
         assign cur = cap_src[g] ? s_q.sync2[g] : s_q.sync2[4];
         assign old = cap_src[g] ? s_q.prev[g]  : s_q.prev[4];
         assign cap_edge[g] = edge_hit(edge_sel[g], cur, old);
         // a buffering c or d register follows channel a or b, not its own pin
         if (g >= 2) begin : g_buf
            assign cap_ev[g] = capture_mode[g] & ~buf_on[g-2] & cap_edge[g];
         end else begin : g_gen
            assign cap_ev[g] = capture_mode[g] & cap_edge[g];
         end
         // compares in timer compare, pwm and pwm2, and while buffering
         assign match[g] = ~capture_mode[g] & count_tick & s_q.mode[`TCCS_MODE_START]
                           & (s_q.cnt == s_q.gr[g]);
      end
   endgenerate

   assign wrap     = count_tick & s_q.mode[`TCCS_MODE_START] & (s_q.cnt == `TCCS_CNT_MAX);
   assign flag_set = {wrap, cap_ev | match};
   assign clr_cnt  = s_q.ctrl1[`TCCS_CTRL1_CLEAR] & (cap_ev[0] | match[0]);

   // bus decode; zero wait states, read data latched in the setup cycle
   assign bus_acc = apb_req.psel & apb_req.penable;
   assign bus_wr  = bus_acc & apb_req.pwrite & mapped;
   assign bus_rd  = bus_acc & ~apb_req.pwrite & mapped;
   assign idx     = apb_req.paddr[11:2];

   assign status_view = {s_q.flag[`TCCS_FLAG_WRAP], 3'h0, s_q.flag[3:0]} | `TCCS_ONES_STATUS;

   always_comb begin
      mapped = 1'b1;
      rd_mux = 32'h0000_0000;
      case (idx)
         `TCCS_IDX_MODE:    rd_mux[7:0] = s_q.mode | `TCCS_ONES_MODE;
         `TCCS_IDX_CTRL1:   rd_mux[7:0] = s_q.ctrl1;
         `TCCS_IDX_IRQ_EN:  rd_mux[7:0] = s_q.irq_en | `TCCS_ONES_IRQ_EN;
         `TCCS_IDX_STATUS:  rd_mux[7:0] = status_view;
         `TCCS_IDX_IO_AB:   rd_mux[7:0] = s_q.io_ab | `TCCS_ONES_IO_AB;
         `TCCS_IDX_IO_CD:   rd_mux[7:0] = s_q.io_cd;
         `TCCS_IDX_COUNTER: rd_mux[15:0] = s_q.cnt;
         `TCCS_IDX_GR_A:    rd_mux[15:0] = s_q.gr[0];
         `TCCS_IDX_GR_B:    rd_mux[15:0] = s_q.gr[1];
         `TCCS_IDX_GR_C:    rd_mux[15:0] = s_q.gr[2];
         `TCCS_IDX_GR_D:    rd_mux[15:0] = s_q.gr[3];
         default:           mapped = 1'b0;
      endcase
   end

   always_comb begin
      logic [4:0] wr_zero;
      logic       fsel;
      wr_zero = 5'h00;
      fsel    = 1'b0;
      s_d = s_q;

      // pins and oscillator pass two flops before any logic looks at them
      s_d.sync1 = {slow_osc_div_signal, chan_d_pin, chan_c_pin, chan_b_pin, chan_a_pin};
      s_d.sync2 = s_q.sync1;
      s_d.prev  = s_q.sync2;

      if (apb_req.psel & ~apb_req.penable) begin
         s_d.rdata = rd_mux;
      end

      // counter: software write wins over counting
      if (clr_cnt) begin
         s_d.cnt = 16'h0000;
      end else if (count_tick & s_q.mode[`TCCS_MODE_START]) begin
         s_d.cnt = s_q.cnt + 16'h0001;
      end

      // general register updates from capture and buffer transfers
      for (int j = 0; j < 2; j++) begin
         if (cap_ev[j]) begin
            s_d.gr[j] = s_q.cnt;
            if (buf_on[j]) begin
               s_d.gr[j+2] = s_q.gr[j];
            end
         end else if (match[j] & buf_on[j]) begin
            s_d.gr[j] = s_q.gr[j+2];
         end
      end
      for (int j = 2; j < 4; j++) begin
         if (cap_ev[j]) begin
            s_d.gr[j] = s_q.cnt;
         end
      end

      // compare outputs: a/b own match, or c/d driving them
      for (int j = 0; j < 2; j++) begin
         fsel = (j == 0) ? s_q.io_cd[`TCCS_IO_C_FUNC] : s_q.io_cd[`TCCS_IO_D_FUNC];
         if (timer_mode[j] & ~capture_mode[j] & match[j]) begin
            s_d.pout[j] = pin_act(edge_sel[j], s_d.pout[j]);
         end
         if (~fsel & timer_mode[j+2] & ~capture_mode[j+2] & match[j+2]) begin
            s_d.pout[j] = pin_act(edge_sel[j+2], s_d.pout[j]);
         end
         if (fsel & ~buf_on[j] & timer_mode[j+2] & ~capture_mode[j+2] & match[j+2]) begin
            s_d.pout[j+2] = pin_act(edge_sel[j+2], s_q.pout[j+2]);
         end
      end

      if (bus_wr) begin
         case (idx)
            `TCCS_IDX_MODE:    s_d.mode   = apb_req.pwdata[7:0] & ~`TCCS_ONES_MODE;
            `TCCS_IDX_CTRL1:   s_d.ctrl1  = apb_req.pwdata[7:0];
            `TCCS_IDX_IRQ_EN:  s_d.irq_en = apb_req.pwdata[7:0] & ~`TCCS_ONES_IRQ_EN;
            `TCCS_IDX_STATUS:  wr_zero = ~{apb_req.pwdata[`TCCS_STATUS_WRAP],
                                           apb_req.pwdata[3:0]};
            `TCCS_IDX_IO_AB:   s_d.io_ab  = apb_req.pwdata[7:0] & ~`TCCS_ONES_IO_AB;
            `TCCS_IDX_IO_CD:   s_d.io_cd  = apb_req.pwdata[7:0];
            `TCCS_IDX_COUNTER: s_d.cnt    = apb_req.pwdata[15:0];
            `TCCS_IDX_GR_A:    s_d.gr[0]  = apb_req.pwdata[15:0];
            `TCCS_IDX_GR_B:    s_d.gr[1]  = apb_req.pwdata[15:0];
            `TCCS_IDX_GR_C:    s_d.gr[2]  = apb_req.pwdata[15:0];
            `TCCS_IDX_GR_D:    s_d.gr[3]  = apb_req.pwdata[15:0];
            default:           s_d.mode   = s_q.mode;
         endcase
      end

      // only bits that read 1 may be cleared by a 0 write, a new event wins
      s_d.flag = (s_q.flag & ~(wr_zero & s_q.arm)) | flag_set;
      if (bus_rd & (idx == `TCCS_IDX_STATUS)) begin
         s_d.arm = {s_q.rdata[`TCCS_STATUS_WRAP], s_q.rdata[3:0]};
      end else if (bus_wr & (idx == `TCCS_IDX_STATUS)) begin
         s_d.arm = 5'h00;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s_q        <= '0;
         s_q.mode   <= `TCCS_RST_MODE & ~`TCCS_ONES_MODE;
         s_q.ctrl1  <= `TCCS_RST_CTRL1;
         s_q.irq_en <= `TCCS_RST_IRQ_EN;
         s_q.io_ab  <= `TCCS_RST_IO_AB;
         s_q.io_cd  <= `TCCS_RST_IO_CD;
         s_q.cnt    <= `TCCS_RST_COUNTER;
         s_q.gr     <= {4{`TCCS_RST_GR}};
      end else begin
         s_q <= s_d;
      end
   end

   assign apb_rsp.prdata  = s_q.rdata;
   assign apb_rsp.pready  = 1'b1;
   assign apb_rsp.pslverr = bus_acc & ~mapped;

   // requests follow the sticky flags, gated by enables
   assign irq_req = s_q.flag & {s_q.irq_en[7], s_q.irq_en[3:0]};

   assign chan_pin_out = s_q.pout;
   // a pin is driven only while its channel compares in timer mode
   assign chan_pin_oe_b[0] = ~(timer_mode[0] & ~capture_mode[0]);
   assign chan_pin_oe_b[1] = ~(timer_mode[1] & ~capture_mode[1]);
   assign chan_pin_oe_b[2] = ~(timer_mode[2] & ~capture_mode[2]
                               & s_q.io_cd[`TCCS_IO_C_FUNC] & ~buf_on[0]);
   assign chan_pin_oe_b[3] = ~(timer_mode[3] & ~capture_mode[3]
                               & s_q.io_cd[`TCCS_IO_D_FUNC] & ~buf_on[1]);

endmodule // tccs_top

//--- tb/tccs_chk.sv
// assertions on the capture/compare block ports
`timescale 1ns/10ps
`include "tccs_defs.svh"

module tccs_chk (
   // clock and reset
   input wire logic                    clk_sys,
   input wire logic                    rst_b,
   // register bus
   input wire tccs_pkg::tccs_apb_req_t apb_req,
   input wire tccs_pkg::tccs_apb_rsp_t apb_rsp,
   // count source and outputs
   input wire logic                    count_tick,
   input wire logic [3:0]              chan_pin_oe_b,
   input wire logic [4:0]              irq_req
);
   localparam logic [11:0] A_STAT = {`TCCS_IDX_STATUS, 2'b00};
   localparam logic [11:0] A_IEN  = {`TCCS_IDX_IRQ_EN, 2'b00};
   logic [9:0] idx;
   logic       acc;
   logic       mapped;
   logic       wr_ien;
   logic [4:0] rd_ones_q;
   logic [4:0] rd_ones_d;
   logic [4:0] keep;
   assign idx    = apb_req.paddr[11:2];
   assign acc    = apb_req.psel && apb_req.penable;
   // odd indices above the counter are the high halves of 16-bit registers
   assign mapped = idx >= `TCCS_IDX_MODE && idx <= `TCCS_IDX_GR_D
                   && !(idx > `TCCS_IDX_COUNTER && idx[0]);
   assign wr_ien = acc && apb_req.pwrite && apb_req.paddr == A_IEN;
   // flags software has seen as one since the last status write
   always_comb begin
      rd_ones_d = rd_ones_q;
      if (acc && apb_req.paddr == A_STAT) begin
         rd_ones_d = apb_req.pwrite ? 5'h00 : {apb_rsp.prdata[7], apb_rsp.prdata[3:0]};
      end
   end
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         rd_ones_q <= 5'h00;
      end else begin
         rd_ones_q <= rd_ones_d;
      end
   end
   assign keep = irq_req & ~(rd_ones_q & ~{apb_req.pwdata[7], apb_req.pwdata[3:0]});

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   sequence s_stat_rd;
      apb_req.psel && !apb_req.penable && !apb_req.pwrite && apb_req.paddr == A_STAT
      ##1 acc && apb_req.paddr == A_STAT;
   endsequence

   a_ready_zero_wait: assert property (acc |-> apb_rsp.pready)
      else $error("pready low in access phase");
   a_stat_ones_read: assert property (
      s_stat_rd |-> {apb_rsp.prdata[31:8], apb_rsp.prdata[6:4]} == 27'h7)
      else $error("status unused bits not read as one");
   a_slverr_unmapped: assert property (acc |-> apb_rsp.pslverr == !mapped)
      else $error("pslverr does not match address map");
   a_unmapped_zero: assert property (acc && !mapped && !apb_req.pwrite |-> apb_rsp.prdata == 32'h0)
      else $error("unmapped read data not zero");
   a_flag_keep_wr: assert property (
      acc && apb_req.pwrite && apb_req.paddr == A_STAT |=> (irq_req & $past(keep)) == $past(keep))
      else $error("status write cleared a flag not read as one");
   a_wrap_has_tick: assert property (
      $rose(irq_req[4]) |-> $past(count_tick) || $past(wr_ien))
      else $error("wrap request without count tick");
   a_reset_quiet: assert property (
      $rose(rst_b) |-> irq_req == 5'h00 && chan_pin_oe_b == 4'b0000)
      else $error("outputs wrong after reset");
   a_word_upper_zero: assert property (
      acc && !apb_req.pwrite && idx >= `TCCS_IDX_COUNTER |-> apb_rsp.prdata[31:16] == 16'h0)
      else $error("16-bit register read upper half not zero");
endmodule // tccs_chk

bind tccs_top tccs_chk chk_u (.clk_sys(clk_sys), .rst_b(rst_b), .apb_req(apb_req),
   .apb_rsp(apb_rsp), .count_tick(count_tick), .chan_pin_oe_b(chan_pin_oe_b), .irq_req(irq_req));

//--- tb/tccs_bench.sv
// self-checking bench for the capture/compare block
`timescale 1ns/10ps

module tccs_bench;
   localparam logic [11:0] ST = 12'h48c;
   localparam logic [11:0] AB = 12'h490;
   localparam logic [11:0] CN = 12'h498;
   localparam logic [11:0] GA = 12'h4a0;
   logic                    clk_sys;
   logic                    rst_b;
   tccs_pkg::tccs_apb_req_t apb_req;
   tccs_pkg::tccs_apb_rsp_t apb_rsp;
   logic                    count_tick;
   logic [3:0]              pin_in;
   logic                    slow_osc;
   logic [3:0]              pin_out;
   logic [3:0]              pin_oe_b;
   logic [4:0]              irq_req;
   logic [31:0]             rd;
   logic                    err;
   int                      n_mismatch;
   int                      checks;
   logic [11:0]             ra [10] = '{12'h48c, 12'h490, 12'h494, 12'h498, 12'h4a0,
                                        12'h4a8, 12'h4b0, 12'h4b8, 12'h480, 12'h488};
   logic [31:0]             re [10] = '{32'h70, 32'h80, 32'h88, 32'h0, 32'hffff,
                                        32'hffff, 32'hffff, 32'hffff, 32'h48, 32'h70};

   tccs_top dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .apb_req(apb_req), .apb_rsp(apb_rsp),
      .count_tick(count_tick), .chan_a_pin(pin_in[0]), .chan_b_pin(pin_in[1]),
      .chan_c_pin(pin_in[2]), .chan_d_pin(pin_in[3]), .slow_osc_div_signal(slow_osc),
      .chan_pin_out(pin_out), .chan_pin_oe_b(pin_oe_b), .irq_req(irq_req));

   always #12.5 clk_sys = ~clk_sys;

   task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("Error %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   // one idle edge first, so a release and the next setup never share a time step
   task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] d);
      @(posedge clk_sys);
      apb_req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
      @(posedge clk_sys);
      apb_req.penable <= 1'b1;
      @(posedge clk_sys);
      while (apb_rsp.pready !== 1'b1) begin
         @(posedge clk_sys);
      end
      rd  = apb_rsp.prdata;
      err = apb_rsp.pslverr;
      apb_req.psel    <= 1'b0;
      apb_req.penable <= 1'b0;
   endtask

   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      xfer(a, 1'b1, d);
   endtask

   task automatic rdchk(input string nm, input logic [11:0] a, input logic [31:0] e);
      xfer(a, 1'b0, 32'h0);
      check(nm, rd, e);
   endtask

   task automatic ticks(input int n);
      count_tick <= 1'b1;
      repeat (n) @(posedge clk_sys);
      count_tick <= 1'b0;
   endtask

   // pins pass two synchronisers and an edge detector before the flag moves
   task automatic pins(input logic [3:0] p, input logic s);
      @(posedge clk_sys);
      pin_in   <= p;
      slow_osc <= s;
      repeat (6) @(posedge clk_sys);
   endtask

   task automatic print_verdict();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask

   initial begin
      repeat (20000) @(posedge clk_sys);
      n_mismatch++;
      print_verdict();
   end

   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      apb_req = '0;
      count_tick = 1'b0;
      pin_in = 4'b0010;
      slow_osc = 1'b0;
      n_mismatch = 0;
      checks = 0;
      repeat (16) @(posedge clk_sys);
      rst_b <= 1'b1;
      check("oe_b", {28'h0, pin_oe_b}, 32'h0);
      for (int i = 0; i < 10; i++) begin
         rdchk("reset value", ra[i], re[i]);
      end
      $display("test reset values done");
      for (int i = 0; i < 4; i++) begin
         wr(GA + 12'(8 * i), 32'h1111 * (i + 1));
         rdchk("general reg", GA + 12'(8 * i), 32'h1111 * (i + 1));
      end
      wr(CN, 32'h0000);
      rdchk("unmapped", 12'h49c, 32'h0);
      check("slverr", {31'h0, err}, 32'h1);
      $display("test register access done");
      wr(GA, 32'h0005);
      wr(12'h480, 32'hc8);
      ticks(10);
      rdchk("counter", CN, 32'h000a);
      @(negedge clk_sys);
      check("irq masked", {27'h0, irq_req}, 32'h0);
      wr(12'h488, 32'h81);
      @(negedge clk_sys);
      check("irq a", {27'h0, irq_req}, 32'h1);
      rdchk("status match", ST, 32'h71);
      wr(ST, 32'hff);
      wr(ST, 32'h00);
      rdchk("status kept", ST, 32'h71);
      wr(ST, 32'h00);
      rdchk("status cleared", ST, 32'h70);
      $display("test compare and flags done");
      wr(CN, 32'hfffe);
      ticks(2);
      rdchk("status wrap", ST, 32'hf0);
      check("irq wrap", {27'h0, irq_req}, 32'h10);
      rdchk("counter wrapped", CN, 32'h0);
      wr(ST, 32'h7f);
      rdchk("wrap cleared", ST, 32'h70);
      $display("test overflow done");
      wr(CN, 32'h0100);
      wr(AB, 32'h5c);
      pins(4'b0001, 1'b0);
      rdchk("status capture", ST, 32'h73);
      rdchk("capture a", GA, 32'h0100);
      rdchk("capture b", 12'h4a8, 32'h0100);
      wr(ST, 32'h00);
      pins(4'b0010, 1'b0);
      wr(AB, 32'h54);
      wr(CN, 32'h0200);
      pins(4'b0011, 1'b0);
      rdchk("pin ignored", ST, 32'h70);
      pins(4'b0010, 1'b1);
      rdchk("osc capture", ST, 32'h71);
      rdchk("osc value", GA, 32'h0200);
      $display("test capture done");
      wr(12'h484, 32'h80);
      wr(AB, 32'h03);
      wr(GA, 32'h0003);
      wr(CN, 32'h0000);
      ticks(6);
      rdchk("counter cleared", CN, 32'h0002);
      check("pin a toggled", {28'h0, pin_out}, 32'h1);
      wr(12'h4b0, 32'h0000);
      wr(12'h494, 32'h83);
      wr(CN, 32'h0000);
      ticks(2);
      check("pin a from c", {28'h0, pin_out}, 32'h0);
      check("oe_b c to a", {28'h0, pin_oe_b}, 32'h4);
      rdchk("status c match", ST, 32'h75);
      wr(ST, 32'h00);
      wr(12'h480, 32'hb8);
      wr(CN, 32'h0000);
      ticks(2);
      rdchk("status c buffer", ST, 32'h74);
      $display("test compare output done");
      print_verdict();
   end
endmodule // tccs_bench
